// >>> dv/crw_properties.sv
// Port checks for the clock, reset and watchdog block
`timescale 1ns/1ps
`default_nettype none
module crw_properties
	import crw_pkg::*;
(
	// Clock, resets and pins
	input wire logic            pclk,
	input wire logic            presetn,
	input wire logic            por_n,
	input wire logic            external_reset_n,
	input wire logic            deep_sleep,
	input wire logic [NSRC-1:0] src_tick,
	// Outputs watched
	input wire logic [5:0]      main_osc_freq,
	input wire logic [NSRC-1:0] osc_en,
	input wire logic            hf_tick,
	input wire logic            radio_sleep_tick,
	input wire logic            sys_reset_n
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ====================
	// Assertions
	a_tick_has_source: assert property (hf_tick |-> $past(src_tick) != '0)
		else $error("root tick without a source tick");
	a_freq_in_range: assert property (main_osc_freq >= FREQ_MIN && main_osc_freq <= FREQ_MAX)
		else $error("main oscillator setting out of range");
	a_low_osc_sleep: assert property (deep_sleep |-> osc_en[1])
		else $error("low-speed oscillator off in deep sleep");
	a_fast_osc_on: assert property (osc_en[2])
		else $error("fast crystal oscillator disabled");
	a_radio_follows: assert property (src_tick[3] |=> radio_sleep_tick)
		else $error("radio sleep tick missing");
	a_radio_quiet: assert property (!src_tick[3] |=> !radio_sleep_tick)
		else $error("spurious radio sleep tick");
	a_pulse_length: assert property ($fell(sys_reset_n) && external_reset_n && por_n |=> !sys_reset_n [*8])
		else $error("system reset pulse too short");
	a_pin_resets: assert property (!external_reset_n |-> !sys_reset_n)
		else $error("pin low without system reset");
	a_pin_release: assert property ($rose(external_reset_n) && por_n |-> ##[1:2] sys_reset_n)
		else $error("system reset held after pin release");
	a_por_resets: assert property (!por_n |-> !sys_reset_n)
		else $error("power-on reset not driving system reset");
	// ====================
	// Coverage
	c_root_tick: cover property (hf_tick);
	c_sys_reset: cover property ($fell(sys_reset_n));
	c_sleep_tick: cover property (deep_sleep && src_tick[3]);
endmodule : crw_properties

bind crw_top crw_properties u_props (.pclk, .presetn, .por_n, .external_reset_n, .deep_sleep,
	.src_tick, .main_osc_freq, .osc_en, .hf_tick, .radio_sleep_tick, .sys_reset_n);
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the clock, reset and watchdog block
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import crw_pkg::*;
;
	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] data;
		logic        err;
	} crw_row_t;
	// ====================
	// Signals
	logic              pclk = 1'b0, presetn = 1'b0, por_n = 1'b0;
	logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0, prdata, rd;
	logic              pready, pslverr, er, prev;
	logic              external_reset_n = 1'b1, deep_sleep = 1'b0;
	logic [NSRC-1:0]   src_tick = '0, osc_en;
	logic [7:0]        trim_latches = 8'ha5, main_osc_trim;
	logic [5:0]        main_osc_freq;
	logic              hf_tick, radio_sleep_tick, analog_tick, sys_reset_n;
	logic [NLINE-1:0]  line_tick;
	int                fails = 0, cmp_count = 0, n, g1, g2, cyc = 0;
	int                order [5] = '{1, 2, 3, 4, 0};
	crw_row_t          rows [11] = '{
		'{1'b0, REG_OSC_FREQ, 32'h18, 1'b0}, '{1'b1, REG_OSC_FREQ, 32'h03, 1'b0},
		'{1'b1, REG_OSC_FREQ, 32'h31, 1'b0}, '{1'b0, REG_OSC_FREQ, 32'h03, 1'b0},
		'{1'b1, REG_OSC_FREQ, 32'h30, 1'b0}, '{1'b0, REG_OSC_FREQ, 32'h30, 1'b0},
		'{1'b0, REG_WDT_LIM, 32'hffff, 1'b0}, '{1'b0, REG_TRIM, 32'ha5, 1'b0},
		'{1'b1, REG_TRIM, 32'h3c, 1'b0}, '{1'b0, 8'h30, 32'h0, 1'b1}, '{1'b1, 8'h30, 32'h1, 1'b1}};

	crw_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .por_n, .external_reset_n, .deep_sleep, .src_tick, .trim_latches,
		.main_osc_freq, .main_osc_trim, .osc_en, .hf_tick, .radio_sleep_tick, .analog_tick,
		.line_tick, .sys_reset_n);

	always #50 pclk = ~pclk;
	// Sources tick at unequal rates so a wrong selection shows on the root tick
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		for (int i = 0; i < NSRC; i++) src_tick[i] <= (cyc % (i + 3)) == 0;
	end
	// ====================
	// Tasks
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk32

	task automatic chk1(input logic got, input logic exp);
		chk32({31'h0, got}, {31'h0, exp});
	endtask : chk1

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			fails++;
			report_and_stop();
		end
	endtask : apb

	task automatic wait_rst(input logic lvl);
		int k;
		k = 0;
		while (sys_reset_n !== lvl && k < 300) begin
			@(posedge pclk);
			k++;
		end
		if (k >= 300) begin
			fails++;
			report_and_stop();
		end
	endtask : wait_rst

	task automatic gap(input int ln, output int g);
		int k;
		k = 0;
		g = 0;
		#1;
		while (line_tick[ln] !== 1'b1 && k < 200) begin
			@(posedge pclk);
			#1;
			k++;
		end
		do begin
			@(posedge pclk);
			#1;
			g++;
		end while (line_tick[ln] !== 1'b1 && g < 200);
	endtask : gap
	// ====================
	// Sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].addr, rows[i].data);
			if (!rows[i].wr) chk32(rd, rows[i].data);
			chk1(er, rows[i].err);
		end
		chk32(32'(main_osc_freq), 32'h30);
		chk32(32'(main_osc_trim), 32'h3c);
		$display("done: register table");
		foreach (order[k]) begin
			apb(1'b1, REG_CLK_SEL, 32'(order[k]));
			n = 0;
			do begin
				apb(1'b0, REG_CLK_SEL, 32'h0);
				n++;
			end while ((rd[16] !== 1'b0 || rd[10:8] !== 3'(order[k])) && n < 20);
			chk32(32'(rd[10:8]), 32'(order[k]));
			@(posedge pclk);
			#1;
			prev = src_tick[order[k]];
			repeat (20) begin
				@(posedge pclk);
				#1;
				chk1(hf_tick, prev);
				prev = src_tick[order[k]];
			end
		end
		apb(1'b1, REG_CLK_SEL, 32'h7);
		apb(1'b0, REG_CLK_SEL, 32'h0);
		chk32(32'(rd[10:8]), 32'(SRC_MAIN));
		$display("done: source switching");
		// Root is the main source, one tick every 3 cycles
		apb(1'b1, REG_DIV_BASE, 32'h8000_0003);
		apb(1'b1, REG_DIV_BASE + 8'h28, 32'h8001_0003);
		apb(1'b1, REG_RTE_BASE, 32'h0);
		apb(1'b1, REG_RTE_BASE + 8'h04, 32'd10);
		apb(1'b1, REG_ANA_SEL, 32'h0);
		gap(0, g1);
		chk32(32'(g1), 32'd12);
		gap(1, g1);
		gap(1, g2);
		chk32(32'(g1 + g2), 32'd27);
		n = 0;
		#1;
		while (analog_tick !== 1'b1 && n < 100) begin
			@(posedge pclk);
			#1;
			n++;
		end
		if (n >= 100) begin
			fails++;
			report_and_stop();
		end
		chk1(line_tick[0], 1'b0);
		@(posedge pclk);
		#1;
		chk1(line_tick[0], 1'b1);
		$display("done: dividers");
		// Window of four low-speed ticks spans 13 to 16 cycles: four to six main ticks
		apb(1'b1, REG_CAL_CTL, 32'h4);
		n = 0;
		do begin
			apb(1'b0, REG_CAL_CTL, 32'h0);
			n++;
		end while (rd[31] !== 1'b0 && n < 20);
		chk32(rd, 32'h4);
		apb(1'b0, REG_CAL_RES, 32'h0);
		chk1(rd >= 32'd4 && rd <= 32'd6, 1'b1);
		$display("done: calibration");
		apb(1'b1, REG_WDT_LIM, 32'd4);
		apb(1'b1, REG_WDT_CTL, 32'h3);
		deep_sleep <= 1'b1;
		apb(1'b1, REG_WDT_SVC, 32'h1);
		apb(1'b0, REG_WDT_CTL, 32'h0);
		chk32(32'(rd[31:17]), 32'h0);
		chk1(sys_reset_n, 1'b1);
		wait_rst(1'b0);
		apb(1'b1, REG_WDT_CTL, 32'h0);
		deep_sleep <= 1'b0;
		wait_rst(1'b1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, REG_OSC_FREQ, 32'h0);
		chk32(rd, 32'h18);
		apb(1'b0, REG_CAUSE, 32'h0);
		chk32(rd, 32'h1);
		apb(1'b1, REG_CAUSE, 32'h1);
		apb(1'b0, REG_CAUSE, 32'h0);
		chk32(rd, 32'h0);
		$display("done: watchdog");
		apb(1'b1, REG_SW_RST, 32'h1);
		wait_rst(1'b0);
		wait_rst(1'b1);
		apb(1'b0, REG_CAUSE, 32'h0);
		chk32(rd, 32'h2);
		apb(1'b1, REG_CAUSE, 32'h2);
		external_reset_n <= 1'b0;
		repeat (5) @(posedge pclk);
		external_reset_n <= 1'b1;
		wait_rst(1'b1);
		apb(1'b0, REG_CAUSE, 32'h0);
		chk32(rd, 32'h4);
		@(posedge pclk);
		por_n <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
		chk1(sys_reset_n, 1'b0);
		@(posedge pclk);
		por_n <= 1'b1;
		wait_rst(1'b1);
		$display("done: reset sources");
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire

// >>> verilog/crw_divider.sv
// Integer or half-step fractional divider of the root clock enable
`timescale 1ns/1ps
`default_nettype none
module crw_divider
	import crw_pkg::*;
#(
	parameter bit FRAC = 1'b0
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Root tick and setting
	input  wire logic         hf_tick,
	input  wire crw_div_cfg_t cfg,
	// Divided tick
	output logic              tick
);
	logic [DIV_W:0] cnt;
	logic           half;
	wire            wrap    = (cnt == '0);
	wire            add_one = FRAC && cfg.frac && half;
	wire [DIV_W:0]  reload  = {1'b0, cfg.value} + {{DIV_W{1'b0}}, add_one};

	// ==========================================================
	// Counter: period is value+1, odd periods stretched by one when half-step is on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt  <= '0;
			half <= 1'b0;
			tick <= 1'b0;
		end else if (!cfg.en) begin
			cnt  <= '0;
			half <= 1'b0;
			tick <= 1'b0;
		end else begin
			tick <= hf_tick && wrap;
			if (hf_tick) begin
				cnt  <= wrap ? reload : cnt - 1'b1;
				half <= wrap ? !half : half;
			end
		end
	end
endmodule : crw_divider
`default_nettype wire

// >>> verilog/crw_pkg.sv
// Package: register map, field layout, reset values and types of the clock/reset/watchdog block
package crw_pkg;
	// ==========================================================
	// Sizes
	localparam int NSRC   = 5;
	localparam int NDIV   = 12;
	localparam int NINT   = 10;
	localparam int NLINE  = 16;
	localparam int DIV_W  = 16;
	// ==========================================================
	// Source codes
	localparam logic [2:0] SRC_MAIN  = 3'h0;
	localparam logic [2:0] SRC_LOW   = 3'h1;
	localparam logic [2:0] SRC_FAST  = 3'h2;
	localparam logic [2:0] SRC_WATCH = 3'h3;
	localparam logic [2:0] SRC_EXT   = 3'h4;
	localparam logic [2:0] SRC_LAST  = 3'h4;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] REG_CLK_SEL  = 8'h00;
	localparam logic [7:0] REG_OSC_FREQ = 8'h04;
	localparam logic [7:0] REG_TRIM     = 8'h08;
	localparam logic [7:0] REG_WDT_CTL  = 8'h0c;
	localparam logic [7:0] REG_WDT_LIM  = 8'h10;
	localparam logic [7:0] REG_WDT_SVC  = 8'h14;
	localparam logic [7:0] REG_CAUSE    = 8'h18;
	localparam logic [7:0] REG_SW_RST   = 8'h1c;
	localparam logic [7:0] REG_CAL_CTL  = 8'h20;
	localparam logic [7:0] REG_CAL_RES  = 8'h24;
	localparam logic [7:0] REG_ANA_SEL  = 8'h28;
	localparam logic [7:0] REG_DIV_BASE = 8'h40;
	localparam logic [7:0] REG_RTE_BASE = 8'h80;
	// ==========================================================
	// Fields and reset values
	localparam int          CAUSE_WDT     = 0;
	localparam int          CAUSE_SW      = 1;
	localparam int          CAUSE_EXT     = 2;
	localparam int          DIV_EN_BIT    = 31;
	localparam int          DIV_FRAC_BIT  = 16;
	localparam logic [5:0]  FREQ_RESET    = 6'h18;
	localparam logic [5:0]  FREQ_MIN      = 6'h03;
	localparam logic [5:0]  FREQ_MAX      = 6'h30;
	localparam logic [15:0] WDT_LIM_RESET = 16'hffff;
	localparam logic [1:0]  SYNC_TICKS    = 2'h2;
	// ==========================================================
	// Timing
	localparam int          CLK_PERIOD_NS = 100;
	localparam int          RST_PULSE_NS  = 1600;
	localparam int          RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0]  RST_PULSE_W   = 5'(RST_PULSE_CYC);
	// ==========================================================
	// Types
	typedef struct packed {
		logic             en;
		logic             frac;
		logic [DIV_W-1:0] value;
	} crw_div_cfg_t;

	typedef struct packed {
		logic             en;
		logic             clk_sel;
		logic [15:0]      limit;
	} crw_wdt_cfg_t;

	typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_SYNC} crw_sw_state_t;
endpackage : crw_pkg

// >>> verilog/crw_top.sv
// Clock source switch, dividers, watchdog, reset control and APB registers
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Source change gates the root tick only between whole periods, never mid-pulse.
// - A new source must tick twice before the root tick follows it.
// - Five sources: main, low-speed, fast crystal, watch crystal, external pin.
// - Main oscillator setting resets to 24 MHz, accepts 3 to 48 in 1 MHz.
// - Trim loads from latches after reset; software may overwrite it later.
// - Low-speed oscillator stays enabled during deep sleep.
// - Main ticks are counted across a window of low-speed ticks.
// - Fast crystal is a selectable root source and always runs for radio.
// - Watch crystal tick is passed on as the radio sleep tick.
// - Watchdog counts low-speed or watch ticks, also during deep sleep.
// - Unserviced watchdog timeout raises a system reset.
// - Watchdog reset sets its bit in the cause record.
// - Twelve dividers: ten integer 16-bit, two with half steps.
// - Sixteen divided lines, each routed from any divider.
// - Analog tick leaves one cycle ahead of the digital lines.
// - Pin and power-on resets act asynchronously on the system reset; software and watchdog requests act on the clock.
// - Cause record is reset only by power-on, so it survives resets.
// - Active-low external reset pin resets the device, no other use.
module crw_top
	import crw_pkg::*;
(
	// APB
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Power-on reset and pins
	input  wire logic              por_n,
	input  wire logic              external_reset_n,
	input  wire logic              deep_sleep,
	// Source ticks: main, low, fast, watch, ext
	input  wire logic [NSRC-1:0]   src_tick,
	input  wire logic [7:0]        trim_latches,
	// Oscillator control
	output logic [5:0]             main_osc_freq,
	output logic [7:0]             main_osc_trim,
	output logic [NSRC-1:0]        osc_en,
	// Clock enables out
	output logic                   hf_tick,
	output logic                   radio_sleep_tick,
	output logic                   analog_tick,
	output logic [NLINE-1:0]       line_tick,
	// System reset
	output logic                   sys_reset_n
);
	// ==========================================================
	// Bus decode
	wire        setup   = psel && !penable;
	wire        wr_acc  = psel && penable && pwrite;
	wire [7:0]  waddr   = paddr;
	wire        is_div  = (paddr >= REG_DIV_BASE) && (paddr < REG_DIV_BASE + 8'(4 * NDIV));
	wire        is_rte  = (paddr >= REG_RTE_BASE) && (paddr < REG_RTE_BASE + 8'(4 * NLINE));
	wire [3:0]  div_idx = 4'((paddr - REG_DIV_BASE) >> 2);
	wire [3:0]  rte_idx = 4'((paddr - REG_RTE_BASE) >> 2);
	wire        aligned = (paddr[1:0] == 2'h0);
	wire        fixed   = (paddr <= REG_ANA_SEL);
	wire        mapped  = aligned && (fixed || is_div || is_rte);

	// ==========================================================
	// Registers
	logic [2:0]          sel_req;
	logic [2:0]          active;
	logic [2:0]          target;
	logic                gate;
	logic [1:0]          sync_cnt;
	crw_sw_state_t       sw_state;
	logic                trim_loaded;
	crw_wdt_cfg_t        wdt_cfg;
	logic [2:0]          cause;
	logic [15:0]         cal_win;
	logic [15:0]         cal_left;
	logic [31:0]         cal_res;
	logic                cal_busy;
	logic [3:0]          ana_sel;
	logic [4:0]          rst_cnt;
	crw_div_cfg_t        div_cfg [NDIV];
	logic [3:0]          route   [NLINE];
	logic [NDIV-1:0]     div_tick;
	logic [NDIV-1:0]     div_dly;
	logic [15:0]         wdt_count;
	logic                wdt_expire;
	logic                ext_s1;
	logic                ext_s2;

	wire  wdt_svc  = wr_acc && (waddr == REG_WDT_SVC);
	wire  sw_rst   = wr_acc && (waddr == REG_SW_RST) && pwdata[0];
	wire  sel_ok   = pwdata[2:0] <= SRC_LAST;
	wire  freq_ok  = (pwdata[5:0] >= FREQ_MIN) && (pwdata[5:0] <= FREQ_MAX) && (pwdata[31:6] == '0);
	wire  tick_old = src_tick[active];
	wire  tick_new = src_tick[target];

	// ==========================================================
	// Simple registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_req       <= SRC_MAIN;
			main_osc_freq <= FREQ_RESET;
			wdt_cfg       <= '{en: 1'b0, clk_sel: 1'b0, limit: WDT_LIM_RESET};
			ana_sel       <= 4'h0;
		end else if (wr_acc) begin
			if (waddr == REG_CLK_SEL && sel_ok) begin
				sel_req <= pwdata[2:0];
			end
			if (waddr == REG_OSC_FREQ && freq_ok) begin
				main_osc_freq <= pwdata[5:0];
			end
			if (waddr == REG_WDT_CTL) begin
				wdt_cfg.en      <= pwdata[0];
				wdt_cfg.clk_sel <= pwdata[1];
			end
			if (waddr == REG_WDT_LIM) begin
				wdt_cfg.limit <= pwdata[15:0];
			end
			if (waddr == REG_ANA_SEL && pwdata[3:0] < 4'(NDIV)) begin
				ana_sel <= pwdata[3:0];
			end
		end
	end

	// ==========================================================
	// Trim: latches first, software afterwards
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim_loaded   <= 1'b0;
			main_osc_trim <= 8'h00;
		end else if (!trim_loaded) begin
			trim_loaded   <= 1'b1;
			main_osc_trim <= trim_latches;
		end else if (wr_acc && waddr == REG_TRIM) begin
			main_osc_trim <= pwdata[7:0];
		end
	end

	// ==========================================================
	// Glitch-free source switch
	// The old source is released just after one of its own pulses so no period is cut,
	// and the new one is trusted only after two of its ticks were seen.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_state <= SW_RUN;
			active   <= SRC_MAIN;
			target   <= SRC_MAIN;
			gate     <= 1'b1;
			sync_cnt <= 2'h0;
			hf_tick  <= 1'b0;
		end else begin
			hf_tick <= gate && tick_old;
			unique case (sw_state)
				SW_RUN: begin
					if (sel_req != active) begin
						target   <= sel_req;
						sw_state <= SW_DRAIN;
					end
				end
				SW_DRAIN: begin
					if (tick_old) begin
						gate     <= 1'b0;
						sync_cnt <= 2'h0;
						sw_state <= SW_SYNC;
					end
				end
				SW_SYNC: begin
					if (tick_new) begin
						sync_cnt <= sync_cnt + 1'b1;
					end
					if (tick_new && sync_cnt == SYNC_TICKS - 2'h1) begin
						active   <= target;
						gate     <= 1'b1;
						sw_state <= SW_RUN;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Oscillator enables and sleep tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_en           <= '1;
			radio_sleep_tick <= 1'b0;
		end else begin
			osc_en[SRC_LOW]   <= 1'b1;
			osc_en[SRC_FAST]  <= 1'b1;
			osc_en[SRC_WATCH] <= 1'b1;
			osc_en[SRC_MAIN]  <= !deep_sleep || active == SRC_MAIN;
			osc_en[SRC_EXT]   <= active == SRC_EXT || target == SRC_EXT;
			radio_sleep_tick  <= src_tick[SRC_WATCH];
		end
	end

	// ==========================================================
	// Low-speed calibration against the main oscillator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_win  <= 16'h0000;
			cal_left <= 16'h0000;
			cal_res  <= 32'h0000_0000;
			cal_busy <= 1'b0;
		end else if (wr_acc && waddr == REG_CAL_CTL && pwdata[15:0] != 16'h0000) begin
			cal_win  <= pwdata[15:0];
			cal_left <= pwdata[15:0];
			cal_res  <= 32'h0000_0000;
			cal_busy <= 1'b1;
		end else if (cal_busy) begin
			if (src_tick[SRC_MAIN]) begin
				cal_res <= cal_res + 1'b1;
			end
			if (src_tick[SRC_LOW]) begin
				cal_left <= cal_left - 1'b1;
				cal_busy <= (cal_left != 16'h0001);
			end
		end
	end

	// ==========================================================
	// Dividers and routing
	// ten integer, two half-step
	for (genvar d = 0; d < NDIV; d++) begin : g_div
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				div_cfg[d] <= '0;
			end else if (wr_acc && is_div && aligned && div_idx == 4'(d)) begin
				div_cfg[d] <= '{en: pwdata[DIV_EN_BIT], frac: pwdata[DIV_FRAC_BIT],
				                value: pwdata[DIV_W-1:0]};
			end
		end
		crw_divider #(.FRAC(d >= NINT)) u_div (
			.pclk    (pclk),
			.presetn (presetn),
			.hf_tick (hf_tick),
			.cfg     (div_cfg[d]),
			.tick    (div_tick[d])
		);
	end

	for (genvar k = 0; k < NLINE; k++) begin : g_line
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				route[k]     <= 4'h0;
				line_tick[k] <= 1'b0;
			end else begin
				if (wr_acc && is_rte && aligned && rte_idx == 4'(k) && pwdata[3:0] < 4'(NDIV)) begin
					route[k] <= pwdata[3:0];
				end
				line_tick[k] <= div_dly[route[k]];
			end
		end
	end

	// analog leads digital by one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_dly     <= '0;
			analog_tick <= 1'b0;
		end else begin
			div_dly     <= div_tick;
			analog_tick <= div_tick[ana_sel];
		end
	end

	// ==========================================================
	// Watchdog
	crw_watchdog u_wdt (
		.pclk       (pclk),
		.presetn    (presetn),
		.cfg        (wdt_cfg),
		.low_tick   (src_tick[SRC_LOW]),
		.watch_tick (src_tick[SRC_WATCH]),
		.service    (wdt_svc),
		.count      (wdt_count),
		.expire     (wdt_expire)
	);

	// ==========================================================
	// System reset: pin clears at once, internal requests stretch a pulse
	wire ext_or_por_n = external_reset_n && por_n;

	always_ff @(posedge pclk or negedge ext_or_por_n) begin
		if (!ext_or_por_n) begin
			rst_cnt     <= 5'h00;
			sys_reset_n <= 1'b0;
		end else if (sw_rst || wdt_expire) begin
			rst_cnt     <= RST_PULSE_W;
			sys_reset_n <= 1'b0;
		end else if (rst_cnt != 5'h00) begin
			rst_cnt     <= rst_cnt - 1'b1;
			sys_reset_n <= (rst_cnt == 5'h01);
		end else begin
			sys_reset_n <= 1'b1;
		end
	end

	// ==========================================================
	// Cause record in the power-on domain
	// pin sampled for the record
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			ext_s1 <= 1'b1;
			ext_s2 <= 1'b1;
		end else begin
			ext_s1 <= external_reset_n;
			ext_s2 <= ext_s1;
		end
	end

	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			cause <= 3'h0;
		end else begin
			cause[CAUSE_WDT] <= wdt_expire ||
			                    (cause[CAUSE_WDT] && !(wr_acc && waddr == REG_CAUSE && pwdata[CAUSE_WDT]));
			cause[CAUSE_SW]  <= sw_rst ||
			                    (cause[CAUSE_SW] && !(wr_acc && waddr == REG_CAUSE && pwdata[CAUSE_SW]));
			cause[CAUSE_EXT] <= !ext_s2 ||
			                    (cause[CAUSE_EXT] && !(wr_acc && waddr == REG_CAUSE && pwdata[CAUSE_EXT]));
		end
	end

	// ==========================================================
	// Read mux
	logic [31:0] rdata;
	always_comb begin
		rdata = 32'h0000_0000;
		if (is_div) begin
			rdata = {div_cfg[div_idx].en, 14'h0000, div_cfg[div_idx].frac, div_cfg[div_idx].value};
		end else if (is_rte) begin
			rdata = {28'h000_0000, route[rte_idx]};
		end else begin
			unique case (paddr)
				REG_CLK_SEL:  rdata = {15'h0000, sw_state != SW_RUN, 5'h00, active, 5'h00, sel_req};
				REG_OSC_FREQ: rdata = {26'h000_0000, main_osc_freq};
				REG_TRIM:     rdata = {24'h00_0000, main_osc_trim};
				REG_WDT_CTL:  rdata = {wdt_count, 14'h0000, wdt_cfg.clk_sel, wdt_cfg.en};
				REG_WDT_LIM:  rdata = {16'h0000, wdt_cfg.limit};
				REG_CAUSE:    rdata = {29'h0000_0000, cause};
				REG_CAL_CTL:  rdata = {cal_busy, 15'h0000, cal_win};
				REG_CAL_RES:  rdata = cal_res;
				REG_ANA_SEL:  rdata = {28'h000_0000, ana_sel};
				default:      rdata = 32'h0000_0000;
			endcase
		end
	end

	// Zero wait states: data is captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (setup) begin
				prdata  <= (mapped && !pwrite) ? rdata : 32'h0000_0000;
				pslverr <= !mapped;
			end
		end
	end
endmodule : crw_top
`default_nettype wire

// >>> verilog/crw_watchdog.sv
// Watchdog counter running on a low-speed source enable
`timescale 1ns/1ps
`default_nettype none
module crw_watchdog
	import crw_pkg::*;
(
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Control
	input  wire crw_wdt_cfg_t cfg,
	input  wire logic         low_tick,
	input  wire logic         watch_tick,
	input  wire logic         service,
	// Status
	output logic [15:0]       count,
	output logic              expire
);
	wire tick = cfg.clk_sel ? watch_tick : low_tick;
	wire hit  = (count >= cfg.limit);

	// ==========================================================
	// Count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count  <= '0;
			expire <= 1'b0;
		end else begin
			expire <= 1'b0;
			if (service || !cfg.en) begin
				count <= '0;
			end else if (tick && hit) begin
				count  <= '0;
				expire <= 1'b1;
			end else if (tick) begin
				count <= count + 1'b1;
			end
		end
	end
endmodule : crw_watchdog
`default_nettype wire
